// file: hdl/ibpd_pkg.sv
// ibpd_pkg: constants, codes and carrier types of the inc/dec, bcd and power-down datapath
// assumes: shared by the top, the alu and the bus slave; no timescale in packages
package ibpd_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int DATA_W = 8;
    localparam int MEM_AW = 6;
    localparam int ADR_W = 10;
    localparam int BUS_W = 32;
    localparam int SYNC_LEN = 3;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [ADR_W-1:0] OFS_CMD = 10'h000;
    localparam logic [ADR_W-1:0] OFS_WORK = 10'h004;
    localparam logic [ADR_W-1:0] OFS_STAT = 10'h008;
    localparam logic [ADR_W-1:0] OFS_MEM = 10'h100;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int CMD_ADR_LSB = 8;
    localparam int ST_ZERO = 0;
    localparam int ST_CARRY = 1;
    localparam int ST_HALF = 2;
    localparam int ST_SLEPT = 3;
    localparam int ST_WDTX = 4;
    localparam int ST_ASLEEP = 5;
    localparam int ST_BUSY = 6;
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;

    // ****************************************
    // operation codes
    // ****************************************
    localparam logic [2:0] OP_INVERT_TO_WORK = 3'h0;
    localparam logic [2:0] OP_BCD_ADJUST_ADD = 3'h1;
    localparam logic [2:0] OP_MINUS_ONE_TO_MEM = 3'h2;
    localparam logic [2:0] OP_MINUS_ONE_TO_WORK = 3'h3;
    localparam logic [2:0] OP_PLUS_ONE_TO_MEM = 3'h4;
    localparam logic [2:0] OP_PLUS_ONE_TO_WORK = 3'h5;
    localparam logic [2:0] OP_POWER_DOWN = 3'h6;

    // ****************************************
    // decimal adjust
    // ****************************************
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic wr_mem;
        logic wr_work;
        logic upd_zero;
        logic upd_carry;
        logic carry;
        logic halt;
    } ibpd_res_type;

    typedef struct packed {
        logic cmd;
        logic work;
        logic stat;
        logic mem;
        logic [MEM_AW-1:0] idx;
    } ibpd_sel_type;

endpackage : ibpd_pkg

// file: hdl/ibpd_alu.sv
// ibpd_alu: combinational result of one datapath operation
// assumes: operands are stable for the execute cycle
`timescale 1ns/1ps
`default_nettype none
module ibpd_alu
    import ibpd_pkg::*;
(
    // operation
    input wire logic [2:0] op_i,
    // operands and flags
    input wire logic [DATA_W-1:0] mem_i,
    input wire logic [DATA_W-1:0] work_i,
    input wire logic carry_i,
    input wire logic half_i,
    // result
    output var ibpd_res_type res_o
);

    logic [DATA_W:0] bcd_sum;
    logic [3:0] fix_lo;
    logic [3:0] fix_hi;

    always_comb
    begin
        res_o = '0;
        fix_lo = (work_i[3:0] > BCD_LIMIT || half_i) ? BCD_FIX : 4'h0;
        fix_hi = (work_i[7:4] > BCD_LIMIT || carry_i) ? BCD_FIX : 4'h0;
        bcd_sum = {1'b0, work_i} + {1'b0, fix_hi, fix_lo};
        unique case (op_i)
            OP_INVERT_TO_WORK:
            begin
                res_o.data = ~mem_i;
                res_o.wr_work = 1'b1;
                res_o.upd_zero = 1'b1;
            end
            OP_BCD_ADJUST_ADD:
            begin
                res_o.data = bcd_sum[DATA_W-1:0];
                res_o.wr_mem = 1'b1;
                res_o.upd_carry = 1'b1;
                res_o.carry = carry_i | bcd_sum[DATA_W];
            end
            OP_MINUS_ONE_TO_MEM, OP_MINUS_ONE_TO_WORK:
            begin
                res_o.data = mem_i - 8'h01;
                res_o.wr_mem = (op_i == OP_MINUS_ONE_TO_MEM);
                res_o.wr_work = (op_i == OP_MINUS_ONE_TO_WORK);
                res_o.upd_zero = 1'b1;
            end
            OP_PLUS_ONE_TO_MEM, OP_PLUS_ONE_TO_WORK:
            begin
                res_o.data = mem_i + 8'h01;
                res_o.wr_mem = (op_i == OP_PLUS_ONE_TO_MEM);
                res_o.wr_work = (op_i == OP_PLUS_ONE_TO_WORK);
                res_o.upd_zero = 1'b1;
            end
            OP_POWER_DOWN:
            begin
                res_o.halt = 1'b1;
            end
            default:
            begin
                res_o = '0;
            end
        endcase
    end

endmodule : ibpd_alu
`default_nettype wire

// file: hdl/ibpd_wb_slave.sv
// ibpd_wb_slave: classic wishbone handshake and address decode
// assumes: master holds the request until it samples ack
`timescale 1ns/1ps
`default_nettype none
module ibpd_wb_slave
    import ibpd_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus request
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    // handshake and decode
    output logic wb_ack_o,
    output logic req_o,
    output logic commit_o,
    output var ibpd_sel_type sel_o
);

    logic ack_r;
    logic ack_nxt;

    function automatic ibpd_sel_type decode(input logic [ADR_W-1:0] a);
        ibpd_sel_type s;
        s = '0;
        s.idx = a[MEM_AW+1:2];
        s.cmd = (a == OFS_CMD);
        s.work = (a == OFS_WORK);
        s.stat = (a == OFS_STAT);
        s.mem = (a[ADR_W-1:MEM_AW+2] == OFS_MEM[ADR_W-1:MEM_AW+2]) && (a[1:0] == 2'h0);
        return s;
    endfunction : decode

    always_comb
    begin
        req_o = wb_cyc_i && wb_stb_i && !ack_r;
        commit_o = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
        ack_nxt = req_o;
        sel_o = decode(wb_adr_i);
        wb_ack_o = ack_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_r <= 1'b0;
        else
            ack_r <= ack_nxt;
    end

endmodule : ibpd_wb_slave
`default_nettype wire

// file: hdl/ibpd_exec.sv
// ibpd_exec: inc/dec, invert, bcd adjust and power-down datapath with wishbone access
// assumes: one 50 MHz clock, synchronous reset, a wake pin from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module ibpd_exec
    import ibpd_pkg::*;
#(
    parameter int MEM_DEPTH = 64
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [BUS_W-1:0] wb_dat_i,
    output logic [BUS_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // wake and watchdog
    input wire logic wake_i,
    input wire logic wdt_timeout_i,
    output logic wdt_clear_o,
    // system clock gate
    output logic clk_run_o
);

    // ****************************************
    // state and storage
    // ****************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_SLEEP
    } ibpd_state_type;

    ibpd_state_type state_r, state_nxt;
    logic [DATA_W-1:0] mem_r [MEM_DEPTH];
    logic [DATA_W-1:0] work_r, work_nxt;
    logic [2:0] op_r, op_nxt;
    logic [MEM_AW-1:0] addr_r, addr_nxt;
    logic zero_r, zero_nxt;
    logic carry_r, carry_nxt;
    logic half_r, half_nxt;
    logic slept_r, slept_nxt;
    logic wdtx_r, wdtx_nxt;
    logic clk_run_r, clk_run_nxt;
    logic wdt_clr_r, wdt_clr_nxt;
    logic [BUS_W-1:0] rdat_r, rdat_nxt;
    logic [SYNC_LEN-1:0] wake_sh_r;
    logic wake_seen;
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [DATA_W-1:0] mem_wd;
    logic [DATA_W-1:0] opnd;
    logic [DATA_W-1:0] stat_vec;
    logic sw_wr;
    logic req;
    logic commit;
    ibpd_sel_type sel;
    ibpd_res_type res;

    // ****************************************
    // bus slave and alu
    // ****************************************
    ibpd_wb_slave u_slave (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_ack_o(wb_ack_o),
        .req_o(req),
        .commit_o(commit),
        .sel_o(sel)
    );

    ibpd_alu u_alu (
        .op_i(op_r),
        .mem_i(opnd),
        .work_i(work_r),
        .carry_i(carry_r),
        .half_i(half_r),
        .res_o(res)
    );

    // ****************************************
    // wake pin synchroniser
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wake_sh_r <= '0;
        else
            wake_sh_r <= {wake_sh_r[SYNC_LEN-2:0], wake_i};
    end

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb
    begin
        opnd = mem_r[addr_r];
        wake_seen = wake_sh_r[1] && wake_sh_r[2];
        stat_vec = '0;
        stat_vec[ST_ZERO] = zero_r;
        stat_vec[ST_CARRY] = carry_r;
        stat_vec[ST_HALF] = half_r;
        stat_vec[ST_SLEPT] = slept_r;
        stat_vec[ST_WDTX] = wdtx_r;
        stat_vec[ST_ASLEEP] = (state_r == ST_SLEEP);
        stat_vec[ST_BUSY] = (state_r != ST_IDLE);
        sw_wr = commit && wb_sel_i[0] && (state_r == ST_IDLE);
        state_nxt = state_r;
        op_nxt = op_r;
        addr_nxt = addr_r;
        work_nxt = work_r;
        zero_nxt = zero_r;
        carry_nxt = carry_r;
        half_nxt = half_r;
        slept_nxt = slept_r;
        wdtx_nxt = wdtx_r;
        clk_run_nxt = clk_run_r;
        wdt_clr_nxt = 1'b0;
        mem_we = 1'b0;
        mem_wa = addr_r;
        mem_wd = res.data;
        rdat_nxt = rdat_r;
        if (req)
        begin
            rdat_nxt = '0;
            if (sel.cmd)
                rdat_nxt = {16'h0000, 2'h0, addr_r, 5'h00, op_r};
            else if (sel.work)
                rdat_nxt[DATA_W-1:0] = work_r;
            else if (sel.stat)
                rdat_nxt[DATA_W-1:0] = stat_vec;
            else if (sel.mem)
                rdat_nxt[DATA_W-1:0] = mem_r[sel.idx];
        end
        unique case (state_r)
            ST_IDLE:
            begin
                if (sw_wr && sel.cmd)
                begin
                    op_nxt = wb_dat_i[2:0];
                    addr_nxt = wb_dat_i[CMD_ADR_LSB+MEM_AW-1:CMD_ADR_LSB];
                    state_nxt = ST_EXEC;
                end
                if (sw_wr && sel.work)
                    work_nxt = wb_dat_i[DATA_W-1:0];
                if (sw_wr && sel.stat)
                begin
                    zero_nxt = wb_dat_i[ST_ZERO];
                    carry_nxt = wb_dat_i[ST_CARRY];
                    half_nxt = wb_dat_i[ST_HALF];
                end
                if (sw_wr && sel.mem)
                begin
                    mem_we = 1'b1;
                    mem_wa = sel.idx;
                    mem_wd = wb_dat_i[DATA_W-1:0];
                end
            end
            ST_EXEC:
            begin
                state_nxt = ST_IDLE;
                if (res.wr_work)
                    work_nxt = res.data;
                mem_we = res.wr_mem;
                // zero flag from the 8-bit result
                if (res.upd_zero)
                    zero_nxt = (res.data == 8'h00);
                if (res.upd_carry)
                    carry_nxt = res.carry;
                if (res.halt)
                begin
                    state_nxt = ST_SLEEP;
                    clk_run_nxt = 1'b0;
                    wdt_clr_nxt = 1'b1;
                    // sleep flag up, expired flag down
                    slept_nxt = 1'b1;
                    wdtx_nxt = 1'b0;
                end
            end
            ST_SLEEP:
            begin
                if (wake_seen)
                begin
                    state_nxt = ST_IDLE;
                    clk_run_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        // a timeout in the clearing cycle is kept
        if (wdt_timeout_i)
            wdtx_nxt = 1'b1;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_IDLE;
            op_r <= OP_INVERT_TO_WORK;
            addr_r <= '0;
            work_r <= WORK_RST;
            zero_r <= 1'b0;
            carry_r <= 1'b0;
            half_r <= 1'b0;
            slept_r <= 1'b0;
            wdtx_r <= 1'b0;
            clk_run_r <= 1'b1;
            wdt_clr_r <= 1'b0;
            rdat_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            addr_r <= addr_nxt;
            work_r <= work_nxt;
            zero_r <= zero_nxt;
            carry_r <= carry_nxt;
            half_r <= half_nxt;
            slept_r <= slept_nxt;
            wdtx_r <= wdtx_nxt;
            clk_run_r <= clk_run_nxt;
            wdt_clr_r <= wdt_clr_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // data memory has no reset, contents survive power-down
    always_ff @(posedge clk_i)
    begin
        if (mem_we)
            mem_r[mem_wa] <= mem_wd;
    end

    assign wb_dat_o = rdat_r;
    assign wdt_clear_o = wdt_clr_r;
    assign clk_run_o = clk_run_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence seq_halt_exec;
        state_r == ST_EXEC && op_r == OP_POWER_DOWN;
    endsequence

    sequence seq_gated;
        !clk_run_o && wdt_clear_o ##1 !clk_run_o && !wdt_clear_o;
    endsequence

    chk_invert_work: assert property (
        state_r == ST_EXEC && op_r == OP_INVERT_TO_WORK |=>
            work_r == ~$past(opnd) && opnd == $past(opnd))
        else $error("invert result wrong");

    chk_bcd_low: assert property (
        state_r == ST_EXEC && op_r == OP_BCD_ADJUST_ADD && half_r |=>
            opnd[3:0] == $past(work_r[3:0]) + 4'h6)
        else $error("bcd low fix wrong");

    // bcd leaves work and zero alone
    chk_bcd_flags: assert property (
        state_r == ST_EXEC && op_r == OP_BCD_ADJUST_ADD |=>
            $stable(zero_r) && $stable(work_r) && $stable(half_r))
        else $error("bcd touched other state");

    chk_dec_mem: assert property (
        state_r == ST_EXEC && op_r == OP_MINUS_ONE_TO_MEM |=>
            opnd == $past(opnd) - 8'h01 && $stable(work_r))
        else $error("decrement to memory wrong");

    chk_inc_work: assert property (
        state_r == ST_EXEC && op_r == OP_PLUS_ONE_TO_WORK |=>
            work_r == $past(opnd) + 8'h01 && $stable(opnd))
        else $error("increment to work wrong");

    chk_zero_work: assert property (
        state_r == ST_EXEC && op_r == OP_MINUS_ONE_TO_WORK |=>
            zero_r == (work_r == 8'h00))
        else $error("zero flag wrong");

    // clock gated, watchdog cleared for one cycle
    chk_pd_clock: assert property (
        seq_halt_exec |=> seq_gated)
        else $error("power-down clock or clear wrong");

    // sleep flag set, expired flag cleared
    chk_pd_flags: assert property (
        seq_halt_exec and !wdt_timeout_i |=>
            slept_r && !wdtx_r && $stable(zero_r) && $stable(carry_r))
        else $error("power-down flags wrong");

    chk_sleep_hold: assert property (
        state_r == ST_SLEEP && $past(state_r) == ST_SLEEP |->
            $stable(work_r) && $stable(opnd) && $stable(carry_r))
        else $error("state changed while asleep");

endmodule : ibpd_exec
`default_nettype wire

// file: testbench/ibpd_wdt_model.sv
// ibpd_wdt_model: watchdog counter and prescaler beside the power-down logic
// assumes: same clock as the datapath; counts only while the system clock runs
`timescale 1ns/1ps
`default_nettype none
module ibpd_wdt_model #(
    parameter logic [15:0] LIMIT = 16'hFFFF
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control from the datapath and the bench
    input wire logic run_i,
    input wire logic clear_i,
    input wire logic trip_i,
    // status
    output logic timeout_o,
    output logic [15:0] count_o,
    output logic [7:0] clears_o
);
    logic [2:0] pre_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pre_r <= 3'h0;
            count_o <= 16'h0000;
            clears_o <= 8'h00;
        end
        else if (clear_i)
        begin
            pre_r <= 3'h0;
            count_o <= 16'h0000;
            clears_o <= clears_o + 8'h01;
        end
        else if (run_i)
        begin
            pre_r <= pre_r + 3'h1;
            if (pre_r == 3'h7)
                count_o <= count_o + 16'h0001;
        end
    end

    // bench trip forces an early expiry
    assign timeout_o = trip_i | (count_o == LIMIT);
endmodule : ibpd_wdt_model
`default_nettype wire

// file: testbench/test_incdec_bcd_power_down_exec.sv
// test_incdec_bcd_power_down_exec: self-checking bench of the datapath over wishbone
// assumes: hdl package and design compiled first, watchdog model beside the design
`timescale 1ns/1ps
`default_nettype none
module test_incdec_bcd_power_down_exec;
    import ibpd_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wake_i, trip;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [BUS_W-1:0] wb_dat_i, wb_dat_o, rd, seed;
    logic wb_ack_o, wdt_timeout_i, wdt_clear_o, clk_run_o;
    logic [15:0] wdt_count;
    logic [7:0] clears, m, w, last_mem, last_work;
    logic [5:0] idx, last_idx;
    logic [2:0] op, f, e_flg;
    logic [18:0] res;
    logic [7:0] corner [4] = '{8'h00, 8'h01, 8'hFF, 8'h9A};
    int err_total, checks, n;

    ibpd_exec dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wake_i(wake_i),
        .wdt_timeout_i(wdt_timeout_i), .wdt_clear_o(wdt_clear_o), .clk_run_o(clk_run_o));
    ibpd_wdt_model wdt (.clk_i(clk_i), .rst_i(rst_i), .run_i(clk_run_o), .clear_i(wdt_clear_o),
        .trip_i(trip), .timeout_o(wdt_timeout_i), .count_o(wdt_count), .clears_o(clears));

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // {half, carry, zero, mem, work} after one operation
    function automatic logic [18:0] exp_op(input logic [2:0] o, input logic [7:0] mv,
        input logic [7:0] wv, input logic [2:0] fl);
        logic [8:0] s;
        logic [7:0] r;
        logic lo, hi;
        lo = (wv[3:0] > 4'h9) | fl[2];
        hi = (wv[7:4] > 4'h9) | fl[1];
        s = {1'b0, wv} + {1'b0, hi ? 4'h6 : 4'h0, lo ? 4'h6 : 4'h0};
        case (o)
            OP_INVERT_TO_WORK: r = ~mv;
            OP_MINUS_ONE_TO_MEM, OP_MINUS_ONE_TO_WORK: r = mv - 8'h01;
            default: r = mv + 8'h01;
        endcase
        case (o)
            OP_BCD_ADJUST_ADD: return {fl[2], fl[1] | s[8], fl[0], s[7:0], wv};
            3'h7: return {fl, mv, wv};
            OP_MINUS_ONE_TO_MEM, OP_PLUS_ONE_TO_MEM: return {fl[2:1], r == 8'h00, r, wv};
            default: return {fl[2:1], r == 8'h00, mv, r};
        endcase
    endfunction : exp_op

    task automatic end_of_test();
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= d;
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && k < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (wb_ack_o !== 1'b1)
        begin
            err_total++;
            end_of_test();
        end
    endtask : wb

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        seed = 32'hFE12;
        err_total = 0;
        checks = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = '0;
        wb_sel_i = 4'hF;
        wb_dat_i = '0;
        wake_i = 1'b0;
        trip = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, OFS_STAT, 32'h0);
        chk("stat reset", rd, 32'h0);
        for (int i = 0; i < 60; i++)
        begin
            idx = 6'(rnd());
            m = (i < 4) ? corner[i] : 8'(rnd());
            w = (i < 4) ? corner[3 - i] : 8'(rnd());
            f = 3'(rnd());
            // code 7 is a no-op and must leave everything alone
            op = (i < 6) ? 3'(i) : (i == 6) ? 3'h7 : 3'(rnd() % 6);
            wb(1'b1, OFS_MEM + 10'({idx, 2'b00}), {24'h0, m});
            wb(1'b1, OFS_WORK, {24'h0, w});
            wb(1'b1, OFS_STAT, {29'h0, f});
            res = exp_op(op, m, w, f);
            wb(1'b1, OFS_CMD, {18'h0, idx, 5'h0, op});
            wb(1'b0, OFS_WORK, 32'h0);
            chk("work", rd, {24'h0, res[7:0]});
            wb(1'b0, OFS_MEM + 10'({idx, 2'b00}), 32'h0);
            chk("mem", rd, {24'h0, res[15:8]});
            wb(1'b0, OFS_STAT, 32'h0);
            chk("stat", rd, {29'h0, res[18:16]});
            last_idx = idx;
            last_mem = res[15:8];
            last_work = res[7:0];
            e_flg = res[18:16];
        end
        // expiry first, so that power-down has a flag to clear
        @(posedge clk_i);
        trip <= 1'b1;
        @(posedge clk_i);
        trip <= 1'b0;
        wb(1'b0, OFS_STAT, 32'h0);
        chk("stat expired", rd, {27'h0, 2'b10, e_flg});
        wb(1'b1, OFS_CMD, {29'h0, OP_POWER_DOWN});
        // gate and watchdog clear both land on the same edge, one edge after execute
        repeat (3) @(posedge clk_i);
        chk("clock run", {31'h0, clk_run_o}, 32'h0);
        chk("wdt clears", {24'h0, clears}, 32'h1);
        wb(1'b0, OFS_STAT, 32'h0);
        // busy reads high while asleep
        chk("stat asleep", rd, {25'h0, 4'b1101, e_flg});
        wb(1'b1, OFS_WORK, 32'h5A);
        wb(1'b1, OFS_CMD, {18'h0, last_idx, 5'h0, OP_PLUS_ONE_TO_MEM});
        chk("wdt count", {16'h0, wdt_count}, 32'h0);
        @(posedge clk_i);
        wake_i <= 1'b1;
        n = 0;
        while (clk_run_o !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            n++;
        end
        wake_i <= 1'b0;
        chk("clock wake", {31'h0, clk_run_o}, 32'h1);
        wb(1'b0, OFS_WORK, 32'h0);
        chk("work kept", rd, {24'h0, last_work});
        wb(1'b0, OFS_MEM + 10'({last_idx, 2'b00}), 32'h0);
        chk("mem kept", rd, {24'h0, last_mem});
        wb(1'b0, OFS_STAT, 32'h0);
        chk("stat woken", rd, {26'h0, 3'b001, e_flg});
        wb(1'b1, 10'h0FC, 32'hFF);
        wb(1'b0, 10'h0FC, 32'h0);
        chk("unmapped", rd, 32'h0);
        end_of_test();
    end
endmodule : test_incdec_bcd_power_down_exec
`default_nettype wire
